// >>> verification/wgt_top_properties.sv
// Purpose : port-level assertions for the windowed guard timer
// Assumes : one clock domain, reset_n asynchronous and active low
// Notes   : timer internals are hidden, so bus timing and the reset pulse are judged
`timescale 1ns/1ps
module wgt_top_props
  import wgt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic chip_reset_reg,
  input wire logic irq_reg
);
  wire w_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // assertions and covers
  // ---------------------------------------------------------------
  AST_RST_HOLD: assert property ($rose(chip_reset_reg) |-> chip_reset_reg [*8])
    else $error("chip reset pulse too short");
  AST_RST_END: assert property ($rose(chip_reset_reg) |-> ##250 !chip_reset_reg)
    else $error("chip reset pulse too long");
  AST_W_ANSWER: assert property (w_take |-> !s_axi_bvalid ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_CLEAR: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  AST_R_CLEAR: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read answer dropped early");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  cover property ($rose(chip_reset_reg));
  cover property ($rose(irq_reg));
  cover property ($fell(irq_reg));
endmodule

bind wgt_top wgt_top_props u_wgt_top_props (.ref_clk, .reset_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .chip_reset_reg, .irq_reg);

// >>> verification/wgt_top_tb.sv
// Purpose : self-checking bench for the windowed guard timer
// Assumes : guard oscillator made here at ref_clk/8, one count step per 32 cycles
// Notes   : expectations come from an integer register model and tick arithmetic
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module wgt_top_tb;
  import wgt_pkg::*;
  logic        ref_clk = 1'b0, reset_n = 1'b0, guard_osc_clock = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb = 4'hF, strb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, chip_reset_reg, irq_reg;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          errors = 0, cmp_count = 0, n, el, c0, ew;
  time         t0;
  int          mdl[int] = '{0:0, 4:'hFF, 12:'hFF, 16:0, 20:'hFFFFFF, 24:0, 32:0, 36:0};
  wgt_top u_wgt_top (.ref_clk, .reset_n, .guard_osc_clock, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_reset_reg, .irq_reg);
  initial forever #2 ref_clk = ~ref_clk;
  always begin
    repeat (4) @(posedge ref_clk);
    guard_osc_clock <= ~guard_osc_clock;
  end
  // ---------------------------------------------------------------
  // bus cycles and checks
  // ---------------------------------------------------------------
  task automatic wrap_up(input int e);
    errors += e;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} <= {a, d, strb, a};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid) break;
    end
    q = s_axi_rdata;
    `CHK(wr ? s_axi_bresp : s_axi_rresp, (a > ADDR_RESET_CAUSE) ? RESP_SLVERR : RESP_OKAY)
    {s_axi_bready, s_axi_rready} <= 2'b00;
    if (n == 100) wrap_up(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge ref_clk);
    `CHK(irq_reg, e)
  endtask
  task automatic wait_hi(input bit rst, input int lim);
    for (n = 0; n < lim && (rst ? chip_reset_reg : irq_reg) !== 1'b1; n++) @(posedge ref_clk);
    el = int'((($time - t0) / 4));
    if (n == lim) wrap_up(1);
  endtask
  initial begin
    void'($urandom(41));
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    foreach (mdl[a]) rd(8'(a), mdl[a]);
    rd(8'h40, 32'h0);
    bus(1'b1, ADDR_TIMEOUT, 32'h10);
    mdl[16] = $urandom;
    bus(1'b1, ADDR_WARN, mdl[16]);
    strb = 4'h1;
    bus(1'b1, ADDR_WARN, 32'hFFFFFFFF);
    strb = 4'hF;
    mdl[16] = mdl[16] & 'hFFFF00 | 'hFF;
    foreach (mdl[a]) rd(8'(a), mdl[a]);
    bus(1'b1, ADDR_WARN, 32'h80);
    $display("test registers done");
    bus(1'b1, ADDR_MODE, 32'h1);
    bus(1'b1, ADDR_MODE, 32'h0);
    rd(ADDR_MODE, 32'h1);
    c0 = int'(q);
    bus(1'b0, ADDR_COUNT, 32'h0);
    c0 = int'(q);
    t0 = $time;
    repeat (320) @(posedge ref_clk);
    bus(1'b0, ADDR_COUNT, 32'h0);
    el = int'((($time - t0) / 4));
    `CHK((c0 - int'(q) - el / 32) inside {0, 1}, 1'b1)
    bus(1'b1, ADDR_FEED, 32'hAA);
    bus(1'b1, ADDR_FEED, 32'h55);
    bus(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q >= 32'hFE, 1'b1)
    $display("test count and feed done");
    bus(1'b1, ADDR_INT_ENABLE, 32'h7);
    bus(1'b1, ADDR_FEED, 32'hAA);
    bus(1'b0, ADDR_INT_STATUS, 32'h0);
    rd(ADDR_INT_STATUS, 32'h4);
    rd(ADDR_MODE, 32'h0);
    chk_irq(1'b1);
    bus(1'b1, ADDR_INT_CLEAR, 32'h7);
    rd(ADDR_INT_STATUS, 32'h0);
    chk_irq(1'b0);
    $display("test broken feed done");
    bus(1'b1, ADDR_WINDOW, 32'h10);
    bus(1'b1, ADDR_MODE, 32'h7);
    bus(1'b1, ADDR_FEED, 32'hAA);
    bus(1'b1, ADDR_FEED, 32'h55);
    wait_hi(1'b1, 20);
    rd(ADDR_RESET_CAUSE, 32'h1);
    rd(ADDR_MODE, 32'h6);
    bus(1'b1, ADDR_RESET_CAUSE, 32'h1);
    rd(ADDR_RESET_CAUSE, 32'h0);
    $display("test early feed done");
    bus(1'b1, ADDR_INT_ENABLE, 32'h2);
    bus(1'b1, ADDR_MODE, 32'h1);
    t0 = $time;
    wait_hi(1'b0, 5000);
    ew = (255 - 128 + 1) * 32;
    `CHK(el inside {[ew - 8 : ew + 48]}, 1'b1)
    bus(1'b1, ADDR_INT_ENABLE, 32'h1);
    chk_irq(1'b0);
    wait_hi(1'b0, 5000);
    ew = 256 * 32;
    `CHK(el inside {[ew - 8 : ew + 48]}, 1'b1)
    rd(ADDR_INT_STATUS, 32'h3);
    rd(ADDR_MODE, 32'h0);
    bus(1'b1, ADDR_INT_CLEAR, 32'h7);
    chk_irq(1'b0);
    $display("test expiry interrupt done");
    bus(1'b1, ADDR_MODE, 32'h3);
    t0 = $time;
    wait_hi(1'b1, 9000);
    `CHK(el inside {[ew - 8 : ew + 48]}, 1'b1)
    rd(ADDR_RESET_CAUSE, 32'h1);
    $display("test expiry reset done");
    bus(1'b1, ADDR_WINDOW, 32'hF8);
    bus(1'b1, ADDR_MODE, 32'h5);
    repeat (600) @(posedge ref_clk);
    bus(1'b1, ADDR_FEED, 32'hAA);
    bus(1'b1, ADDR_FEED, 32'h55);
    bus(1'b0, ADDR_COUNT, 32'h0);
    `CHK(q >= 32'hFE, 1'b1)
    rd(ADDR_MODE, 32'h5);
    $display("test window feed done");
    wrap_up(0);
  end
endmodule

// >>> verilog/wgt_axil_slave.sv
// Purpose : AXI4-Lite slave front end for the guard timer registers
// Assumes : at most one write and one read outstanding
// Notes   : address and data of a write may come in either order
`timescale 1ns/1ps
module wgt_axil_slave
  import wgt_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic                   rd_en,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);

  logic aw_have_reg;
  logic w_have_reg;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic aw_have_next;
  logic w_have_next;
  logic bvalid_next;
  logic rvalid_next;

  // readies are flops fed from next state, so they drop the edge an item is held
  assign aw_have_next  = ~wr_en & (aw_have_reg | aw_take);
  assign w_have_next   = ~wr_en & (w_have_reg | w_take);
  assign bvalid_next   = wr_en | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_next   = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  assign wr_en         = aw_have_reg & w_have_reg;
  assign rd_en         = ar_take;
  assign rd_addr       = s_axi_araddr;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      wr_addr      <= '0;
      wr_data      <= '0;
      wr_strb      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_have_next & ~bvalid_next;
      s_axi_wready  <= ~w_have_next & ~bvalid_next;
      s_axi_arready <= ~rvalid_next;
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        wr_addr     <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        wr_data    <= s_axi_wdata;
        wr_strb    <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> verilog/wgt_pkg.sv
// Purpose : shared constants, types and helpers of the windowed guard timer
// Assumes : 32-bit AXI4-Lite register bus, one clock at 250 MHz
// Notes   : register word offsets are byte addresses on the bus
package wgt_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W            = 8;
  localparam logic [7:0]  ADDR_MODE         = 8'h00;
  localparam logic [7:0]  ADDR_TIMEOUT      = 8'h04;
  localparam logic [7:0]  ADDR_FEED         = 8'h08;
  localparam logic [7:0]  ADDR_COUNT        = 8'h0C;
  localparam logic [7:0]  ADDR_WARN         = 8'h10;
  localparam logic [7:0]  ADDR_WINDOW       = 8'h14;
  localparam logic [7:0]  ADDR_INT_STATUS   = 8'h18;
  localparam logic [7:0]  ADDR_INT_CLEAR    = 8'h1C;
  localparam logic [7:0]  ADDR_INT_ENABLE   = 8'h20;
  localparam logic [7:0]  ADDR_RESET_CAUSE  = 8'h24;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned MODE_EN_BIT       = 0;
  localparam int unsigned MODE_RST_BIT      = 1;
  localparam int unsigned MODE_WIN_BIT      = 2;
  localparam int unsigned CAUSE_BIT         = 0;
  localparam int unsigned CNT_W             = 24;
  localparam logic [23:0] TIMEOUT_MIN       = 24'h0000FF;
  localparam logic [23:0] TIMEOUT_RST       = 24'h0000FF;
  localparam logic [23:0] WINDOW_RST        = 24'hFFFFFF;
  localparam logic [23:0] WARN_RST          = 24'h000000;
  localparam logic [7:0]  FEED_KEY_FIRST    = 8'hAA;
  localparam logic [7:0]  FEED_KEY_SECOND   = 8'h55;
  localparam int unsigned INT_W             = 3;
  localparam int unsigned INT_TIMEOUT_BIT   = 0;
  localparam int unsigned INT_WARN_BIT      = 1;
  localparam int unsigned INT_FAULT_BIT     = 2;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned PRESCALE          = 4;
  localparam int unsigned OSC_FREQ_KHZ      = 500;
  localparam int unsigned CLK_FREQ_MHZ      = 250;
  localparam int unsigned RESET_PULSE_NS    = 1000;
  localparam int unsigned RESET_PULSE_CYC   = (RESET_PULSE_NS * CLK_FREQ_MHZ) / 1000;
  localparam int unsigned RST_CNT_W         = $clog2(RESET_PULSE_CYC + 1);

  typedef enum logic {
    FEED_IDLE,
    FEED_ARMED
  } wgt_feed_e;

  // merge a bus write into an old word under byte enables
  function automatic logic [31:0] wgt_apply_strb(input logic [31:0] old_word,
                                                 input logic [31:0] new_word,
                                                 input logic [3:0]  strb);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// >>> verilog/wgt_prescaler.sv
// Purpose : turns guard oscillator rising edges into one count tick per PRESCALE rising edges
// Assumes : guard_osc_clock is a level synchronous to ref_clk, much slower
// Notes   : the count restarts whenever the timer is not running
`timescale 1ns/1ps
module wgt_prescaler
  import wgt_pkg::*;
#(
  parameter int unsigned DIV = PRESCALE
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic run,
  input  wire logic guard_osc_clock,
  output logic      count_tick
);

  localparam int unsigned DW = $clog2(DIV);

  logic          osc_prev_reg;
  logic [DW-1:0] div_reg;
  logic          osc_rise;
  logic          div_last;

  assign osc_rise = guard_osc_clock & ~osc_prev_reg;
  assign div_last = (div_reg == DW'(DIV - 1));

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_prev_reg <= 1'b0;
      div_reg      <= '0;
      count_tick   <= 1'b0;
    end else begin
      osc_prev_reg <= guard_osc_clock;
      count_tick   <= run & osc_rise & div_last;
      if (!run) begin
        div_reg <= '0;
      end else if (osc_rise) begin
        div_reg <= div_last ? '0 : DW'(div_reg + 1'b1);
      end
    end
  end

endmodule

// >>> verilog/wgt_top.sv
// Purpose : windowed guard timer with reset, warning and fault interrupts
// Assumes : guard_osc_clock is a slow level sampled on ref_clk
// Notes   : chip_reset is a pulse; this block's own flops keep their state
`timescale 1ns/1ps
module wgt_top
  import wgt_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              guard_osc_clock,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   chip_reset_reg,
  output logic                   irq_reg
);

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_err;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_err;

  wgt_axil_slave u_bus (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_en         (rd_en),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic             en_reg;
  logic             rst_mode_reg;
  logic             win_mode_reg;
  logic [CNT_W-1:0] timeout_reg;
  logic [CNT_W-1:0] warn_reg;
  logic [CNT_W-1:0] window_reg;
  logic [CNT_W-1:0] count_reg;
  logic [INT_W-1:0] int_status_reg;
  logic [INT_W-1:0] int_enable_reg;
  logic             cause_reg;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  wgt_feed_e        feed_state_reg;
  wgt_feed_e        feed_state_next;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire wr_mode    = wr_en && (wr_addr == ADDR_MODE);
  wire wr_timeout = wr_en && (wr_addr == ADDR_TIMEOUT);
  wire wr_feed    = wr_en && (wr_addr == ADDR_FEED);
  wire wr_warn    = wr_en && (wr_addr == ADDR_WARN);
  wire wr_window  = wr_en && (wr_addr == ADDR_WINDOW);
  wire wr_int_clr = wr_en && (wr_addr == ADDR_INT_CLEAR);
  wire wr_int_en  = wr_en && (wr_addr == ADDR_INT_ENABLE);
  wire wr_cause   = wr_en && (wr_addr == ADDR_RESET_CAUSE);
  wire wr_ro      = (wr_addr == ADDR_COUNT) || (wr_addr == ADDR_INT_STATUS);

  assign wr_err = ~(wr_mode | wr_timeout | wr_feed | wr_warn | wr_window |
                    wr_int_clr | wr_int_en | wr_cause | wr_ro);

  wire [31:0] mode_word = {29'h0, win_mode_reg, rst_mode_reg, en_reg};
  wire [31:0] mode_wr   = wgt_apply_strb(mode_word, wr_data, wr_strb);
  wire [31:0] tmo_wr    = wgt_apply_strb({8'h0, timeout_reg}, wr_data, wr_strb);
  wire [31:0] warn_wr   = wgt_apply_strb({8'h0, warn_reg}, wr_data, wr_strb);
  wire [31:0] win_wr    = wgt_apply_strb({8'h0, window_reg}, wr_data, wr_strb);
  wire [31:0] feed_wr   = wgt_apply_strb(32'h0, wr_data, wr_strb);

  // short timeouts are raised to the floor instead of refused
  wire [CNT_W-1:0] tmo_clamped = (tmo_wr[CNT_W-1:0] < TIMEOUT_MIN) ?
                                 TIMEOUT_MIN : tmo_wr[CNT_W-1:0];

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  assign rd_data =
    (rd_addr == ADDR_MODE)        ? mode_word :
    (rd_addr == ADDR_TIMEOUT)     ? {8'h0, timeout_reg} :
    (rd_addr == ADDR_COUNT)       ? {8'h0, count_reg} :
    (rd_addr == ADDR_WARN)        ? {8'h0, warn_reg} :
    (rd_addr == ADDR_WINDOW)      ? {8'h0, window_reg} :
    (rd_addr == ADDR_INT_STATUS)  ? {29'h0, int_status_reg} :
    (rd_addr == ADDR_INT_ENABLE)  ? {29'h0, int_enable_reg} :
    (rd_addr == ADDR_RESET_CAUSE) ? {31'h0, cause_reg} : 32'h0;

  assign rd_err = ~((rd_addr == ADDR_MODE) || (rd_addr == ADDR_TIMEOUT) ||
                    (rd_addr == ADDR_FEED) || (rd_addr == ADDR_COUNT) ||
                    (rd_addr == ADDR_WARN) || (rd_addr == ADDR_WINDOW) ||
                    (rd_addr == ADDR_INT_STATUS) || (rd_addr == ADDR_INT_CLEAR) ||
                    (rd_addr == ADDR_INT_ENABLE) || (rd_addr == ADDR_RESET_CAUSE));

  // ---------------------------------------------------------------
  // oscillator prescaler
  // ---------------------------------------------------------------
  logic count_tick;

  // the oscillator only matters while enabled; when idle the divider rests
  wgt_prescaler #(
    .DIV (PRESCALE)
  ) u_presc (
    .ref_clk         (ref_clk),
    .reset_n         (reset_n),
    .run             (en_reg),
    .guard_osc_clock (guard_osc_clock),
    .count_tick      (count_tick)
  );

  // ---------------------------------------------------------------
  // service sequence
  // ---------------------------------------------------------------
  wire key_first  = wr_feed && (feed_wr[7:0] == FEED_KEY_FIRST);
  wire key_second = wr_feed && (feed_wr[7:0] == FEED_KEY_SECOND);
  wire any_access = wr_en || rd_en;

  logic feed_done;
  logic seq_bad;

  always_comb begin
    feed_state_next = feed_state_reg;
    feed_done       = 1'b0;
    seq_bad         = 1'b0;
    case (feed_state_reg)
      FEED_IDLE: begin
        if (key_first) begin
          feed_state_next = FEED_ARMED;
        end
      end
      FEED_ARMED: begin
        if (key_second) begin
          feed_done       = 1'b1;
          feed_state_next = FEED_IDLE;
        end else if (any_access) begin
          seq_bad         = 1'b1;
          feed_state_next = FEED_IDLE;
        end
      end
      default: begin
        feed_state_next = FEED_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // trip conditions
  // ---------------------------------------------------------------
  // an early service in window mode is a fault, not a reload
  wire early      = win_mode_reg && (count_reg > window_reg);
  wire fault      = en_reg && (seq_bad || (feed_done && early));
  wire reload     = en_reg && feed_done && !early;
  wire expire     = en_reg && count_tick && (count_reg == '0);
  wire warn_hit   = en_reg && count_tick && (count_reg == warn_reg);
  wire trip       = fault || expire;
  wire trip_reset = trip && rst_mode_reg;
  wire start      = wr_mode && mode_wr[MODE_EN_BIT] && !en_reg;

  wire [INT_W-1:0] int_set = {fault && !rst_mode_reg, warn_hit, expire && !rst_mode_reg};
  wire [INT_W-1:0] int_clr = wr_int_clr ? wr_data[INT_W-1:0] : '0;

  // ---------------------------------------------------------------
  // control and mode
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_reg       <= 1'b0;
      rst_mode_reg <= 1'b0;
      win_mode_reg <= 1'b0;
    end else begin
      // software can only set enable; a trip takes precedence
      if (trip) begin
        en_reg <= 1'b0;
      end else if (start) begin
        en_reg <= 1'b1;
      end
      if (wr_mode) begin
        rst_mode_reg <= mode_wr[MODE_RST_BIT];
        win_mode_reg <= mode_wr[MODE_WIN_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_reg <= TIMEOUT_RST;
      warn_reg    <= WARN_RST;
      window_reg  <= WINDOW_RST;
    end else begin
      if (wr_timeout) begin
        timeout_reg <= tmo_clamped;
      end
      if (wr_warn) begin
        warn_reg <= warn_wr[CNT_W-1:0];
      end
      if (wr_window) begin
        window_reg <= win_wr[CNT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------
  // no power-down input gates the step: a running timer keeps counting
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg      <= TIMEOUT_RST;
      feed_state_reg <= FEED_IDLE;
    end else begin
      feed_state_reg <= feed_state_next;
      if (start || reload || trip) begin
        count_reg <= timeout_reg;
      end else if (count_tick && (count_reg != '0)) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // chip reset pulse and cause flag
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_reg    <= '0;
      chip_reset_reg <= 1'b0;
      cause_reg      <= 1'b0;
    end else begin
      if (trip_reset) begin
        rst_cnt_reg <= RST_CNT_W'(RESET_PULSE_CYC);
      end else if (rst_cnt_reg != '0) begin
        rst_cnt_reg <= rst_cnt_reg - 1'b1;
      end
      chip_reset_reg <= trip_reset || (rst_cnt_reg > RST_CNT_W'(1));
      // set wins over a clear landing in the same cycle
      if (trip_reset) begin
        cause_reg <= 1'b1;
      end else if (wr_cause && wr_data[CAUSE_BIT]) begin
        cause_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_status_reg <= '0;
      int_enable_reg <= '0;
      irq_reg        <= 1'b0;
    end else begin
      int_status_reg <= (int_status_reg & ~int_clr) | int_set;
      if (wr_int_en) begin
        int_enable_reg <= wr_data[INT_W-1:0];
      end
      irq_reg <= |(int_status_reg & int_enable_reg);
    end
  end

endmodule
